// ---- src/dios_map.svh ----
`ifndef DIOS_MAP_SVH
`define DIOS_MAP_SVH
// Register byte offsets
`define DIOS_CTRL_OFS 12'h000
`define DIOS_MBADDR_OFS 12'h004
`define DIOS_OUTBYTE_OFS 12'h008
`define DIOS_INBYTE_OFS 12'h00C
`define DIOS_STATUS_OFS 12'h010
// Control field positions
`define DIOS_CTRL_G2OUT_BIT 0
`define DIOS_CTRL_MODEA_LSB 1
`define DIOS_CTRL_MODEB_LSB 3
`define DIOS_CTRL_INVA_BIT 5
`define DIOS_CTRL_INVB_BIT 6
// Reset values
`define DIOS_CTRL_RST 32'h0000_0000
`define DIOS_MBADDR_RST 8'h01
// Output byte layout
`define DIOS_G1_LSB 0
`define DIOS_G2_LSB 2
// Bus responses
`define DIOS_RESP_OKAY 2'h0
`define DIOS_RESP_SLVERR 2'h2
// Timing, in milliseconds, and clock rate in kHz
`define DIOS_CLK_KHZ 10000
`define DIOS_FLASH_MS 250
`define DIOS_PULSE_MS 50
`define DIOS_ACT_MS 50
`define DIOS_FLASH_CYC (`DIOS_FLASH_MS * `DIOS_CLK_KHZ)
`define DIOS_PULSE_CYC (`DIOS_PULSE_MS * `DIOS_CLK_KHZ)
`define DIOS_ACT_CYC (`DIOS_ACT_MS * `DIOS_CLK_KHZ)
`endif

// ---- src/dios_pkg.sv ----
package dios_pkg;
  // Source of a group 1 output
  typedef enum logic [1:0] {
    DIOS_MODE_DIRECT,
    DIOS_MODE_PULSE,
    DIOS_MODE_CMP,
    DIOS_MODE_RSVD
  } dios_mode_t;
  typedef logic [23:0] dios_cnt_t;
endpackage

// ---- src/dios_top.sv ----
`timescale 1ns/1ns
// Notes on behaviour
// - Two fixed group 1 outputs and three group 2 pins usable either way.
// - Group 2 direction is one setting for all three pins.
// - Group 2 inputs appear in input byte bits 0 to 2.
// - With group 2 as outputs, output byte bits 0 to 4 drive outputs.
// - Each group 2 output follows its output byte bit; each group 1 output in direct mode follows it XORed with its inversion bit.
// - Output byte accepted from both serial and Ethernet fieldbus sides.
// - Group 1 output states shown on two display indicators.
// - Display indicator ignores the normally-open/closed inversion.
// - Each group 2 pin has its own status LED.
// - Each group 1 output may act as a pulse output.
// - Each group 1 output may carry a comparator result.
// - Green Ethernet LED steady while link is up, dark otherwise.
// - Yellow Ethernet LED blinks while traffic is seen on that port.
// - Ready LED flashes while initialising, steady when ready.
// - System fault LED on for configuration or system error.
// - Bus fault LED on without link, flashing without session, off in session.
// - Serial commands taken only when the frame address matches ours.
// - Group 2 input LED green while a signal is present.
// - Output LED red while the output is commanded active.
`include "dios_map.svh"
module dios_top
  import dios_pkg::*;
#(
  parameter int FLASH_CYC = `DIOS_FLASH_CYC,
  parameter int PULSE_CYC = `DIOS_PULSE_CYC,
  parameter int ACT_CYC = `DIOS_ACT_CYC
)(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [7:0] fbOutByte,
  input wire logic fbOutWe,
  input wire logic [7:0] mbOutByte,
  input wire logic [7:0] mbFrameAddr,
  input wire logic mbOutWe,
  output logic [7:0] fbInByte,
  input wire logic [1:0] pulseReq,
  input wire logic [1:0] cmpResult,
  output logic [1:0] g1PinOut,
  output logic group1_output_a_indicator,
  output logic group1_output_b_indicator,
  input wire logic [2:0] g2PinIn,
  output logic [2:0] g2PinOut,
  output logic [2:0] g2PinOe,
  output logic [2:0] g2LedGreen,
  output logic [2:0] g2LedRed,
  input wire logic [1:0] ethLink,
  input wire logic [1:0] ethActivity,
  output logic [1:0] ethLedGreen,
  output logic [1:0] ethLedYellow,
  input wire logic initDone,
  input wire logic cfgError,
  input wire logic sysError,
  input wire logic sessionActive,
  output logic readyLed,
  output logic system_fault_led,
  output logic bus_fault_led
);
  // Register file
  logic [31:0] ctrlReg;
  logic [7:0] mbAddrReg;
  logic [4:0] outByteReg;
  logic [4:0] outByteNext;
  // Bus slave state
  logic awHaveReg;
  logic wHaveReg;
  logic [11:0] awAddrReg;
  logic [31:0] wDataReg;
  logic [3:0] wStrbReg;
  // Synchronisers for pin inputs
  logic [2:0] g2Sync1Reg;
  logic [2:0] g2Sync2Reg;
  logic [1:0] linkSync1Reg;
  logic [1:0] linkSync2Reg;
  logic [1:0] actSync1Reg;
  logic [1:0] actSync2Reg;
  logic [1:0] actPrevReg;
  // Timers
  dios_cnt_t flashCntReg;
  logic flashPhaseReg;
  dios_cnt_t pulseCntReg [2];
  dios_cnt_t actCntReg [2];
  logic [1:0] g1State;

  // Control fields
  wire g2IsOut = ctrlReg[`DIOS_CTRL_G2OUT_BIT];
  wire dios_mode_t modeA = dios_mode_t'(ctrlReg[`DIOS_CTRL_MODEA_LSB +: 2]);
  wire dios_mode_t modeB = dios_mode_t'(ctrlReg[`DIOS_CTRL_MODEB_LSB +: 2]);
  wire [1:0] invert = {ctrlReg[`DIOS_CTRL_INVB_BIT], ctrlReg[`DIOS_CTRL_INVA_BIT]};

  // Write path decode
  wire doWrite = awHaveReg && wHaveReg && !s_axi_bvalid;
  wire wrCtrl = doWrite && (awAddrReg == `DIOS_CTRL_OFS);
  wire wrMbAddr = doWrite && (awAddrReg == `DIOS_MBADDR_OFS);
  wire wrHit = wrCtrl || wrMbAddr;
  wire [31:0] byteMask = {{8{wStrbReg[3]}}, {8{wStrbReg[2]}}, {8{wStrbReg[1]}}, {8{wStrbReg[0]}}};
  wire [31:0] ctrlWr = (ctrlReg & ~byteMask) | (wDataReg & byteMask);

  // Read path decode
  wire [31:0] statusWord = {19'h0, readyLed, system_fault_led, bus_fault_led,
                            ethLedYellow, ethLedGreen, g2LedRed, g2LedGreen};
  wire rdCtrl = (s_axi_araddr == `DIOS_CTRL_OFS);
  wire rdMbAddr = (s_axi_araddr == `DIOS_MBADDR_OFS);
  wire rdOut = (s_axi_araddr == `DIOS_OUTBYTE_OFS);
  wire rdIn = (s_axi_araddr == `DIOS_INBYTE_OFS);
  wire rdStat = (s_axi_araddr == `DIOS_STATUS_OFS);
  wire rdHit = rdCtrl || rdMbAddr || rdOut || rdIn || rdStat;
  wire [31:0] rdWord = rdCtrl ? ctrlReg :
                       rdMbAddr ? {24'h0, mbAddrReg} :
                       rdOut ? {27'h0, outByteReg} :
                       rdIn ? {24'h0, fbInByte} :
                       rdStat ? statusWord : 32'h0000_0000;

  // Write address and data channels, taken in either order
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      awHaveReg <= 1'b0;
      wHaveReg <= 1'b0;
      awAddrReg <= 12'h000;
      wDataReg <= 32'h0000_0000;
      wStrbReg <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        awHaveReg <= 1'b1;
        awAddrReg <= {s_axi_awaddr[11:2], 2'b00};
      end
      else if (doWrite)
        awHaveReg <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
      begin
        wHaveReg <= 1'b1;
        wDataReg <= s_axi_wdata;
        wStrbReg <= s_axi_wstrb;
      end
      else if (doWrite)
        wHaveReg <= 1'b0;
    end
  end

  // Ready flags and write response
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `DIOS_RESP_OKAY;
    end
    else
    begin
      s_axi_awready <= !awHaveReg && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
      s_axi_wready <= !wHaveReg && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
      if (doWrite)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wrHit ? `DIOS_RESP_OKAY : `DIOS_RESP_SLVERR;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // Read channel
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `DIOS_RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rdWord;
        s_axi_rresp <= rdHit ? `DIOS_RESP_OKAY : `DIOS_RESP_SLVERR;
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // Configuration registers
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrlReg <= `DIOS_CTRL_RST;
      mbAddrReg <= `DIOS_MBADDR_RST;
    end
    else
    begin
      if (wrCtrl)
        ctrlReg <= {25'h0, ctrlWr[6:0]};
      if (wrMbAddr && wStrbReg[0])
        mbAddrReg <= wDataReg[7:0];
    end
  end

  // Output byte source selection
  // own address only
  wire mbAccept = mbOutWe && (mbFrameAddr == mbAddrReg);
  wire [4:0] cmdByte = fbOutWe ? fbOutByte[4:0] : mbOutByte[4:0];
  wire cmdWe = fbOutWe || mbAccept;
  wire [4:0] cmdMasked = g2IsOut ? cmdByte : {3'b000, cmdByte[1:0]};
  always_comb
  begin
    outByteNext = outByteReg;
    if (cmdWe)
      outByteNext = cmdMasked;
    else if (!g2IsOut)
      outByteNext = {3'b000, outByteReg[1:0]};
  end

  // Output byte storage
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      outByteReg <= 5'h00;
    else
      outByteReg <= outByteNext;
  end

  // Pin input synchronisers
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      g2Sync1Reg <= 3'h0;
      g2Sync2Reg <= 3'h0;
      linkSync1Reg <= 2'h0;
      linkSync2Reg <= 2'h0;
      actSync1Reg <= 2'h0;
      actSync2Reg <= 2'h0;
      actPrevReg <= 2'h0;
    end
    else
    begin
      g2Sync1Reg <= g2PinIn;
      g2Sync2Reg <= g2Sync1Reg;
      linkSync1Reg <= ethLink;
      linkSync2Reg <= linkSync1Reg;
      actSync1Reg <= ethActivity;
      actSync2Reg <= actSync1Reg;
      actPrevReg <= actSync2Reg;
    end
  end

  // Shared flash phase for status LEDs
  wire flashWrap = (flashCntReg == dios_cnt_t'(FLASH_CYC - 1));
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      flashCntReg <= 24'h00_0000;
      flashPhaseReg <= 1'b0;
    end
    else
    begin
      flashCntReg <= flashWrap ? 24'h00_0000 : flashCntReg + 24'h00_0001;
      if (flashWrap)
        flashPhaseReg <= !flashPhaseReg;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_port
      always_ff @(posedge clk_sys or negedge rst_n)
      begin
        if (!rst_n)
          pulseCntReg[gi] <= 24'h00_0000;
        else if (pulseReq[gi] && pulseCntReg[gi] == 24'h00_0000)
          pulseCntReg[gi] <= dios_cnt_t'(PULSE_CYC);
        else if (pulseCntReg[gi] != 24'h00_0000)
          pulseCntReg[gi] <= pulseCntReg[gi] - 24'h00_0001;
      end
      always_ff @(posedge clk_sys or negedge rst_n)
      begin
        if (!rst_n)
          actCntReg[gi] <= 24'h00_0000;
        else if (actSync2Reg[gi] != actPrevReg[gi] && actCntReg[gi] == 24'h00_0000)
          actCntReg[gi] <= dios_cnt_t'(2 * ACT_CYC);
        else if (actCntReg[gi] != 24'h00_0000)
          actCntReg[gi] <= actCntReg[gi] - 24'h00_0001;
      end
    end
  endgenerate

  // Group 1 output state by mode
  function automatic logic g1Select(input dios_mode_t mode, input logic direct,
                                    input logic pulse, input logic cmp);
    logic sel;
    sel = direct;
    unique case (mode)
      DIOS_MODE_DIRECT: sel = direct;
      DIOS_MODE_PULSE: sel = pulse;
      DIOS_MODE_CMP: sel = cmp;
      DIOS_MODE_RSVD: sel = direct;
    endcase
    return sel;
  endfunction
  assign g1State[0] = g1Select(modeA, outByteReg[`DIOS_G1_LSB],
                               pulseCntReg[0] != 24'h00_0000, cmpResult[0]);
  assign g1State[1] = g1Select(modeB, outByteReg[`DIOS_G1_LSB + 1],
                               pulseCntReg[1] != 24'h00_0000, cmpResult[1]);
  wire [2:0] g2Cmd = outByteReg[`DIOS_G2_LSB +: 3];

  // Pin drive and indicator outputs
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      g1PinOut <= 2'b00;
      group1_output_a_indicator <= 1'b0;
      group1_output_b_indicator <= 1'b0;
      g2PinOut <= 3'b000;
      g2PinOe <= 3'b000;
      g2LedGreen <= 3'b000;
      g2LedRed <= 3'b000;
      fbInByte <= 8'h00;
    end
    else
    begin
      g1PinOut <= g1State ^ invert;
      group1_output_a_indicator <= g1State[0];
      group1_output_b_indicator <= g1State[1];
      // bits 2 to 4 drive group 2
      g2PinOut <= g2IsOut ? g2Cmd : 3'b000;
      g2PinOe <= {3{g2IsOut}};
      g2LedGreen <= g2IsOut ? 3'b000 : g2Sync2Reg;
      g2LedRed <= g2IsOut ? g2Cmd : 3'b000;
      // inputs in bits 0 to 2
      fbInByte <= g2IsOut ? 8'h00 : {5'h00, g2Sync2Reg};
    end
  end
  // per-pin LEDs are g2LedGreen and g2LedRed above

  // Network and status LEDs
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ethLedGreen <= 2'b00;
      ethLedYellow <= 2'b00;
      readyLed <= 1'b0;
      system_fault_led <= 1'b0;
      bus_fault_led <= 1'b1;
    end
    else
    begin
      ethLedGreen <= linkSync2Reg;
      ethLedYellow <= {actCntReg[1] > dios_cnt_t'(ACT_CYC), actCntReg[0] > dios_cnt_t'(ACT_CYC)};
      readyLed <= initDone ? 1'b1 : flashPhaseReg;
      system_fault_led <= cfgError || sysError;
      bus_fault_led <= !(|linkSync2Reg) ? 1'b1 : (sessionActive ? 1'b0 : flashPhaseReg);
    end
  end
endmodule

// ---- verif/dios_properties.sv ----
`timescale 1ns/1ns
module dios_properties (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [7:0] fbInByte,
  input wire logic [2:0] g2PinOut,
  input wire logic [2:0] g2PinOe,
  input wire logic [2:0] g2LedGreen,
  input wire logic [2:0] g2LedRed,
  input wire logic [1:0] ethLink,
  input wire logic [1:0] ethLedGreen,
  input wire logic initDone,
  input wire logic cfgError,
  input wire logic sysError,
  input wire logic sessionActive,
  input wire logic readyLed,
  input wire logic system_fault_led,
  input wire logic bus_fault_led
);
  logic [2:0] upCnt_reg;
  logic settled;
  // Cycles since reset release, saturating, so sync stages have filled
  always_ff @(posedge clk_sys or negedge rst_n)
    if (!rst_n)
      upCnt_reg <= 3'h0;
    else if (upCnt_reg != 3'h7)
      upCnt_reg <= upCnt_reg + 3'h1;
  assign settled = (upCnt_reg == 3'h7);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  // Steady conditions that the LED relations wait for
  sequence dirSteady;
    (settled && $stable(g2PinOe)) [*2];
  endsequence
  sequence linkSteady;
    (settled && $stable(ethLink)) [*4];
  endsequence
  sequence noLink;
    (settled && ethLink == 2'h0) [*5];
  endsequence
  sequence inSession;
    (settled && ethLink != 2'h0 && sessionActive) [*5];
  endsequence
  fbin_upper_zero_a: assert property (fbInByte[7:3] == 5'h00)
    else $error("input byte upper bits set");
  g2_dir_whole_a: assert property (g2PinOe == 3'h0 || g2PinOe == 3'h7)
    else $error("group 2 direction mixed");
  inbyte_outmode_a: assert property (dirSteady ##0 g2PinOe == 3'h7 |-> fbInByte == 8'h00)
    else $error("input byte live in output mode");
  red_led_cmd_a: assert property (dirSteady |-> g2LedRed == (g2PinOut & g2PinOe))
    else $error("red LED differs from output");
  green_led_in_a: assert property (dirSteady |-> g2LedGreen == (fbInByte[2:0] & ~g2PinOe))
    else $error("green LED differs from input");
  eth_green_link_a: assert property (linkSteady |-> ethLedGreen == ethLink)
    else $error("link LED differs from link");
  bf_no_link_a: assert property (noLink |-> bus_fault_led)
    else $error("bus fault dark without link");
  bf_session_a: assert property (inSession |-> !bus_fault_led)
    else $error("bus fault lit in session");
  sf_error_a: assert property (settled |-> system_fault_led == $past(cfgError || sysError))
    else $error("system fault LED wrong");
  ready_steady_a: assert property (settled && $past(initDone) |-> readyLed)
    else $error("ready LED dark when ready");
endmodule

// ---- verif/dios_plc_model.sv ----
`timescale 1ns/1ns
module dios_plc_model (
  input wire logic clk_sys,
  output logic [7:0] fbOutByte,
  output logic fbOutWe,
  output logic [7:0] mbOutByte,
  output logic [7:0] mbFrameAddr,
  output logic mbOutWe
);
  // Idle lines at time zero
  initial
  begin
    fbOutByte = 8'h00;
    fbOutWe = 1'h0;
    mbOutByte = 8'h00;
    mbFrameAddr = 8'h00;
    mbOutWe = 1'h0;
  end
  task automatic sendFb(input logic [7:0] b);
    @(posedge clk_sys);
    fbOutByte <= b;
    fbOutWe <= 1'h1;
    @(posedge clk_sys);
    fbOutWe <= 1'h0;
    fbOutByte <= ~b; // Released lines show the inverse
  endtask
  // serial frame with target address, after an idle gap
  task automatic sendMb(input logic [7:0] a, input logic [7:0] b, input int gap);
    repeat (gap) @(posedge clk_sys);
    @(posedge clk_sys);
    mbFrameAddr <= a;
    mbOutByte <= b;
    mbOutWe <= 1'h1;
    @(posedge clk_sys);
    mbOutWe <= 1'h0;
    mbFrameAddr <= ~a;
    mbOutByte <= ~b;
  endtask
endmodule

// ---- verif/dios_tb_top.sv ----
`timescale 1ns/1ns
`include "dios_map.svh"
module dios_tb_top;
  localparam int FLASH = 8, PULSE = 5, ACT = 4;
  typedef struct packed {
    logic [7:0] ctrl;
    logic mb;
    logic [7:0] adr;
    logic [7:0] cmd;
    logic [1:0] g1;
    logic [1:0] ind;
    logic [2:0] g2;
    logic [7:0] ob;
  } dios_row_t;
  logic clk_sys = 1'h0, rst_n = 1'h0;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [31:0] s_axi_rdata, q;
  logic [7:0] fbOutByte, mbOutByte, mbFrameAddr, fbInByte;
  logic fbOutWe, mbOutWe, group1_output_a_indicator, group1_output_b_indicator;
  logic [1:0] pulseReq = 2'h0, cmpResult = 2'h0, ethLink = 2'h0, ethActivity = 2'h0;
  logic [1:0] g1PinOut, ethLedGreen, ethLedYellow;
  logic [2:0] g2PinIn = 3'h0;
  logic [2:0] g2PinOut, g2PinOe, g2LedGreen, g2LedRed;
  logic initDone = 1'h0, cfgError = 1'h0, sysError = 1'h0, sessionActive = 1'h0;
  logic readyLed, system_fault_led, bus_fault_led;
  int fails = 0, nChecks = 0, hp, hy, nr, nb;
  // Direction, inversion, source, command and expected pins
  dios_row_t rows [6] = '{
    '{8'h00, 1'h0, 8'h00, 8'h1F, 2'h3, 2'h3, 3'h0, 8'h03},
    '{8'h01, 1'h0, 8'h00, 8'h15, 2'h1, 2'h1, 3'h5, 8'h15},
    '{8'h21, 1'h0, 8'h00, 8'h0A, 2'h3, 2'h2, 3'h2, 8'h0A},
    '{8'h61, 1'h1, 8'h01, 8'h03, 2'h0, 2'h3, 3'h0, 8'h03},
    '{8'h01, 1'h1, 8'h02, 8'h00, 2'h3, 2'h3, 3'h0, 8'h03},
    '{8'h40, 1'h1, 8'h01, 8'h1E, 2'h0, 2'h2, 3'h0, 8'h02}};
  dios_top #(.FLASH_CYC(FLASH), .PULSE_CYC(PULSE), .ACT_CYC(ACT)) i_dut (.*);
  dios_plc_model i_plc (.*);
  always #50 clk_sys = ~clk_sys;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    nChecks++;
    if (got !== exp)
    begin
      fails++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, got, exp);
    end
  endtask
  // Register write, channels released one by one as taken
  task automatic axw(input logic [11:0] a, input logic [31:0] d);
    logic pa, pw;
    pa = 1'h1;
    pw = 1'h1;
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (pa || pw)
    begin
      @(posedge clk_sys);
      pa = pa && !s_axi_awready;
      pw = pw && !s_axi_wready;
      s_axi_awvalid <= pa;
      s_axi_wvalid <= pw;
    end
    do @(posedge clk_sys); while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask
  task automatic axr(input logic [11:0] a);
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do @(posedge clk_sys); while (!s_axi_arready);
    s_axi_arvalid <= 1'h0;
    do @(posedge clk_sys); while (!s_axi_rvalid);
    q = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask
  // Counts high cycles and LED toggles over a window
  task automatic watch(input int n);
    logic pr, pb;
    {hp, hy, nr, nb} = '0;
    pr = readyLed;
    pb = bus_fault_led;
    repeat (n)
    begin
      @(negedge clk_sys);
      hp += g1PinOut[0];
      hy += ethLedYellow[0];
      nr += (readyLed != pr);
      nb += (bus_fault_led != pb);
      pr = readyLed;
      pb = bus_fault_led;
    end
  endtask
  task automatic results();
    if (fails == 0 && nChecks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    repeat (4000) @(posedge clk_sys);
    fails++;
    results();
  end
  initial
  begin
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'h1;
    foreach (rows[i])
    begin
      axw(`DIOS_CTRL_OFS, {24'h00_0000, rows[i].ctrl});
      if (rows[i].mb)
        i_plc.sendMb(rows[i].adr, rows[i].cmd, i);
      else
        i_plc.sendFb(rows[i].cmd);
      settle(1);
      chk(g1PinOut, rows[i].g1);
      chk({group1_output_b_indicator, group1_output_a_indicator}, rows[i].ind);
      chk(g2PinOut, rows[i].g2);
      chk(g2PinOe, {3{rows[i].ctrl[0]}});
      axr(`DIOS_OUTBYTE_OFS);
      chk(q, rows[i].ob);
    end
    @(posedge clk_sys);
    rst_n <= 1'h0;
    @(negedge clk_sys);
    chk({g1PinOut, g2PinOe, bus_fault_led}, 6'h01);
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'h1;
    axr(`DIOS_CTRL_OFS);
    chk(q, `DIOS_CTRL_RST);
    axr(`DIOS_MBADDR_OFS);
    chk(q, 32'h0000_0001);
    axw(`DIOS_MBADDR_OFS, 32'h0000_0022);
    axw(`DIOS_CTRL_OFS, 32'h0000_0001);
    // Foreign address comes last, so taking it would show on the pins
    i_plc.sendMb(8'h22, 8'h14, 0);
    i_plc.sendMb(8'h01, 8'h1F, 0);
    settle(1);
    chk(g2PinOut, 3'h5);
    axw(12'h020, 32'h0000_0001);
    chk(r, `DIOS_RESP_SLVERR);
    axr(12'h020);
    chk(r, `DIOS_RESP_SLVERR);
    axw(`DIOS_CTRL_OFS, 32'h0000_0000);
    @(posedge clk_sys);
    g2PinIn <= 3'h5;
    settle(3);
    chk({fbInByte, g2LedGreen}, 11'h02D);
    axr(`DIOS_INBYTE_OFS);
    chk(q, 32'h0000_0005);
    // pulse length, retrigger while running ignored
    axw(`DIOS_CTRL_OFS, 32'h0000_0003);
    settle(2);
    chk(fbInByte, 8'h00);
    @(posedge clk_sys);
    pulseReq <= 2'h1;
    repeat (2) @(posedge clk_sys);
    pulseReq <= 2'h0;
    watch(20);
    chk(hp, PULSE);
    axw(`DIOS_CTRL_OFS, 32'h0000_0005);
    @(posedge clk_sys);
    cmpResult <= 2'h1;
    settle(2);
    chk(g1PinOut, 2'h1);
    @(posedge clk_sys);
    cmpResult <= 2'h2;
    settle(2);
    chk(g1PinOut, 2'h0);
    // Output B from its comparator, output A in the spare mode code
    axw(`DIOS_CTRL_OFS, 32'h0000_0017);
    settle(1);
    chk(g1PinOut, 2'h2);
    // link up, flashing before ready and session
    @(posedge clk_sys);
    ethLink <= 2'h1;
    settle(4);
    chk(ethLedGreen, 2'h1);
    watch(40);
    chk(nr > 3 && nb > 3, 1'h1);
    // one activity burst, ready, session, fault
    @(posedge clk_sys);
    ethActivity <= 2'h1;
    initDone <= 1'h1;
    sessionActive <= 1'h1;
    cfgError <= 1'h1;
    watch(20);
    chk(hy, ACT);
    chk({readyLed, bus_fault_led, system_fault_led}, 3'h5);
    @(posedge clk_sys);
    cfgError <= 1'h0;
    sysError <= 1'h1;
    ethLink <= 2'h0;
    settle(5);
    chk({system_fault_led, bus_fault_led}, 2'h3);
    axr(`DIOS_STATUS_OFS);
    chk(q, 32'h0000_1C00);
    results();
  end
endmodule
bind dios_top dios_properties i_props (.*);
